// ### rtl/sfs_pkg.sv
// package: command codes, field positions, reason codes and state encodings for the sanitize handler
package sfs_pkg;
  localparam logic [7:0]  SFS_CMD_SANITIZE    = 8'hB4;
  localparam logic [15:0] SFS_FEAT_STATUS     = 16'h0000;
  localparam logic [15:0] SFS_FEAT_OVERWRITE  = 16'h0014;
  localparam logic [15:0] SFS_FEAT_FREEZE     = 16'h0020;
  // freeze key in address fields: sector number cur/prev, cylinder low/high cur
  localparam logic [7:0]  SFS_KEY_SECNUM_CUR  = 8'h6B;
  localparam logic [7:0]  SFS_KEY_SECNUM_PREV = 8'h46;
  localparam logic [7:0]  SFS_KEY_CYLLO_CUR   = 8'h4C;
  localparam logic [7:0]  SFS_KEY_CYLHI_CUR   = 8'h72;
  // sector count field positions
  localparam int SFS_SC_CLEAR_FAILED = 0;
  localparam int SFS_SC_FAIL_EXIT    = 4;
  localparam int SFS_SC_SUCCEEDED    = 15;
  localparam int SFS_SC_IN_PROGRESS  = 14;
  localparam int SFS_SC_FROZEN       = 13;
  // error and status register bit positions
  localparam int SFS_ERR_ABORT  = 2;
  localparam int SFS_STS_BUSY   = 7;
  localparam int SFS_STS_READY  = 6;
  localparam int SFS_STS_SEEK   = 4;
  localparam int SFS_STS_ERROR  = 0;
  // reason codes returned in sector number on error
  localparam logic [7:0] SFS_RSN_NONE     = 8'h00;
  localparam logic [7:0] SFS_RSN_FAILED   = 8'h01;
  localparam logic [7:0] SFS_RSN_BADFEAT  = 8'h02;
  localparam logic [7:0] SFS_RSN_FROZEN   = 8'h03;
  localparam logic [15:0] SFS_PROGRESS_IDLE = 16'hFFFF;
  localparam logic [7:0]  SFS_STATUS_RESET  = 8'h50;
  localparam logic [7:0]  SFS_ERROR_RESET   = 8'h00;

  typedef enum logic [4:0] {
    SFS_SANITIZE_IDLE_STATE      = 5'b00001,
    SFS_SANITIZE_FROZEN_STATE    = 5'b00010,
    SFS_SANITIZE_OPERATION_STATE = 5'b00100,
    SFS_SANITIZE_FAILED_STATE    = 5'b01000,
    SFS_SANITIZE_SUCCEEDED_STATE = 5'b10000
  } sfs_state_e;

  // one command as presented by the command block registers
  typedef struct packed {
    logic [7:0]  command;
    logic [15:0] feature;
    logic [15:0] sectorCount;
    logic [15:0] sectorNumber;
    logic [15:0] cylinderLow;
    logic [15:0] cylinderHigh;
  } sfs_cmd_s;

  // returned command block input registers
  typedef struct packed {
    logic [7:0]  commandErrorFlags;
    logic [7:0]  deviceStatusFlags;
    logic [15:0] sectorCount;
    logic [7:0]  sectorNumber;
    logic [7:0]  cylinderLow;
  } sfs_reply_s;
endpackage

// ### rtl/sfs_cmd_decode.sv
// decoder: classifies a command block into sanitize sub-commands
`timescale 1ns/10ps
`default_nettype none
module sfs_cmd_decode (
  // command in
  input  wire sfs_pkg::sfs_cmd_s cmd,
  // classification
  output logic                   isSanitize,
  output logic                   isFreeze,
  output logic                   isStatus,
  output logic                   isOverwrite,
  output logic                   keyMatch
);
  import sfs_pkg::*;

  // pure decode, no state
  always_comb begin
    isSanitize  = (cmd.command == SFS_CMD_SANITIZE);
    isFreeze    = isSanitize && (cmd.feature == SFS_FEAT_FREEZE); // R1
    isStatus    = isSanitize && (cmd.feature == SFS_FEAT_STATUS); // R2
    isOverwrite = isSanitize && (cmd.feature == SFS_FEAT_OVERWRITE);
    // freeze key check; a wrong key makes the request invalid
    keyMatch    = (cmd.sectorNumber == {SFS_KEY_SECNUM_PREV, SFS_KEY_SECNUM_CUR}) &&
                  (cmd.cylinderLow[7:0] == SFS_KEY_CYLLO_CUR) &&
                  (cmd.cylinderHigh[7:0] == SFS_KEY_CYLHI_CUR); // R20
  end
endmodule
`default_nettype wire

// ### rtl/sfs_persist_flag.sv
// flag held on a separate retention reset so it survives power-on reset
`timescale 1ns/10ps
`default_nettype none
module sfs_persist_flag (
  // clock and retention reset
  input  wire  logic core_clk,
  input  wire  logic retain_rst_n,
  // update
  input  wire  logic setFlag,
  input  wire  logic clearFlag,
  output logic       flag
);
  logic next_flag;

  // set wins over clear when both arrive together
  always_comb begin
    next_flag = flag;
    if (clearFlag) begin
      next_flag = 1'b0;
    end
    if (setFlag) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge retain_rst_n) begin
    if (!retain_rst_n) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end
endmodule
`default_nettype wire

// ### rtl/sfs_sanitize_handler.sv
// sanitize freeze-lock and status command handler with the sanitize state machine
// Notes on behaviour
// R1 - B4h with feature 0020h means freeze-lock
// R2 - B4h with feature 0000h means status query
// R3 - accepted freeze-lock enters frozen state
// R4 - frozen: abort all sanitize except status
// R5 - only power-on or hardware reset unfreezes
// R6 - status query accepted in every state
// R7 - status reports progress, outcome, unsupported request; status in frozen or failed state drops a pending unsupported note instead
// R8 - failed to idle on clear with permission
// R9 - clear without permission aborts status query
// R10 - bit 15 success flag survives power-on reset
// R11 - bit 14 shows sanitize in progress
// R12 - bit 13 shows frozen state
// R13 - progress high in cylinder low, low in sector number
// R14 - progress reads FFFFh outside operation state
// R15 - error reason code in sector number
// R16 - status after failed sanitize returns abort
// R17 - record fail-exit permission of each operation
// R18 - abort sanitize requests after completed freeze-lock
// R19 - abort sets abort and error, clears busy
// R20 - host sends freeze key; mismatch is invalid
`timescale 1ns/10ps
`default_nettype none
module sfs_sanitize_handler (
  // clock and resets
  input  wire  logic                core_clk,
  input  wire  logic                arst_n,
  input  wire  logic                retain_rst_n,
  // command block in
  input  wire  logic                cmdValid,
  input  wire  sfs_pkg::sfs_cmd_s   cmd,
  // media engine side
  input  wire  logic                opDone,
  input  wire  logic                opFailed,
  input  wire  logic [15:0]         opProgress,
  output logic                      opStart,
  // command block out
  output logic                      cmdBusy,
  output logic                      cmdDone,
  output sfs_pkg::sfs_reply_s       reply,
  output sfs_pkg::sfs_state_e       sanitizeState
);
  import sfs_pkg::*;

  logic isSanitize;
  logic isFreeze;
  logic isStatus;
  logic isOverwrite;
  logic keyMatch;
  logic succeededFlag;
  logic setSucceeded;
  logic clearSucceeded;

  sfs_cmd_decode u_decode (
    .cmd        (cmd),
    .isSanitize (isSanitize),
    .isFreeze   (isFreeze),
    .isStatus   (isStatus),
    .isOverwrite(isOverwrite),
    .keyMatch   (keyMatch)
  );

  sfs_persist_flag u_succeeded (
    .core_clk    (core_clk),
    .retain_rst_n(retain_rst_n),
    .setFlag     (setSucceeded),
    .clearFlag   (clearSucceeded),
    .flag        (succeededFlag)
  );

  sfs_state_e  next_sanitizeState;
  logic        failExit;
  logic        next_failExit;
  logic        frozenSeen;
  logic        next_frozenSeen;
  logic        badFeatSeen;
  logic        next_badFeatSeen;
  logic        next_cmdDone;
  logic        next_opStart;
  sfs_reply_s  next_reply;
  logic        doAbort;
  logic [7:0]  reason;
  logic [15:0] progress;

  assign cmdBusy = 1'b0; // every sanitize command is answered on the next edge

  // state machine, recorded flags and reply computation
  always_comb begin
    next_sanitizeState = sanitizeState;
    next_failExit      = failExit;
    next_frozenSeen    = frozenSeen;
    next_badFeatSeen   = badFeatSeen;
    next_cmdDone       = 1'b0;
    next_opStart       = 1'b0;
    next_reply         = reply;
    setSucceeded       = 1'b0;
    clearSucceeded     = 1'b0;
    doAbort            = 1'b0;
    reason             = SFS_RSN_NONE;
    // engine completion moves operation to an outcome state
    if (sanitizeState == SFS_SANITIZE_OPERATION_STATE && opDone) begin
      if (opFailed) begin
        next_sanitizeState = SFS_SANITIZE_FAILED_STATE;
      end else begin
        next_sanitizeState = SFS_SANITIZE_SUCCEEDED_STATE;
        setSucceeded       = 1'b1; // R10
      end
    end
    // progress is only meaningful while running
    progress = (sanitizeState == SFS_SANITIZE_OPERATION_STATE) ? opProgress : SFS_PROGRESS_IDLE; // R14
    if (cmdValid && isSanitize) begin
      next_cmdDone = 1'b1;
      if (isStatus) begin // R6
        // status is legal in every state, frozen and failed included
        if (cmd.sectorCount[SFS_SC_CLEAR_FAILED] && sanitizeState == SFS_SANITIZE_FAILED_STATE) begin
          if (failExit) begin
            next_sanitizeState = SFS_SANITIZE_IDLE_STATE; // R8
          end else begin
            doAbort = 1'b1; // R9
            reason  = SFS_RSN_FAILED;
          end
        end else if (sanitizeState == SFS_SANITIZE_FAILED_STATE) begin
          doAbort = 1'b1; // R16
          reason  = SFS_RSN_FAILED;
        end else if (badFeatSeen && sanitizeState != SFS_SANITIZE_FROZEN_STATE) begin
          // the pending note leaves through the error output; frozen status never aborts,
          // so a note taken before freezing is dropped there
          doAbort = 1'b1; // R7
          reason  = SFS_RSN_BADFEAT; // R7
        end
        next_badFeatSeen = 1'b0;
      end else if (sanitizeState == SFS_SANITIZE_FROZEN_STATE || frozenSeen) begin
        doAbort = 1'b1; // R4 R18
        reason  = SFS_RSN_FROZEN;
      end else if (isFreeze && keyMatch) begin
        if (sanitizeState != SFS_SANITIZE_OPERATION_STATE) begin
          next_sanitizeState = SFS_SANITIZE_FROZEN_STATE; // R3
          next_frozenSeen    = 1'b1;
        end else begin
          doAbort = 1'b1;
        end
      end else if (isOverwrite && sanitizeState != SFS_SANITIZE_OPERATION_STATE &&
                   !(sanitizeState == SFS_SANITIZE_FAILED_STATE && !failExit &&
                     cmd.sectorCount[SFS_SC_FAIL_EXIT])) begin
        next_sanitizeState = SFS_SANITIZE_OPERATION_STATE;
        next_failExit      = cmd.sectorCount[SFS_SC_FAIL_EXIT]; // R17
        clearSucceeded     = 1'b1; // R10
        next_opStart       = 1'b1;
      end else begin
        doAbort          = 1'b1; // R20
        reason           = SFS_RSN_BADFEAT;
        next_badFeatSeen = 1'b1;
      end
      // reply fields
      next_reply.sectorCount = 16'h0000;
      next_reply.sectorCount[SFS_SC_SUCCEEDED]   = succeededFlag | setSucceeded; // R10
      next_reply.sectorCount[SFS_SC_IN_PROGRESS] = (sanitizeState == SFS_SANITIZE_OPERATION_STATE); // R11
      next_reply.sectorCount[SFS_SC_FROZEN]      = (next_sanitizeState == SFS_SANITIZE_FROZEN_STATE); // R12
      next_reply.cylinderLow  = progress[15:8]; // R13
      next_reply.sectorNumber = doAbort ? reason : progress[7:0]; // R15
      next_reply.commandErrorFlags = SFS_ERROR_RESET;
      next_reply.commandErrorFlags[SFS_ERR_ABORT] = doAbort; // R19
      next_reply.deviceStatusFlags = SFS_STATUS_RESET;
      next_reply.deviceStatusFlags[SFS_STS_BUSY]  = 1'b0; // R19
      next_reply.deviceStatusFlags[SFS_STS_ERROR] = doAbort; // R19
    end
  end

  // registers; arst_n is the power-on or hardware reset that unfreezes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sanitizeState <= SFS_SANITIZE_IDLE_STATE; // R5
      failExit      <= 1'b0;
      frozenSeen    <= 1'b0; // R18
      badFeatSeen   <= 1'b0;
      cmdDone       <= 1'b0;
      opStart       <= 1'b0;
      reply         <= '{SFS_ERROR_RESET, SFS_STATUS_RESET, 16'h0000, 8'h00, 8'h00};
    end else begin
      sanitizeState <= next_sanitizeState;
      failExit      <= next_failExit;
      frozenSeen    <= next_frozenSeen;
      badFeatSeen   <= next_badFeatSeen;
      cmdDone       <= next_cmdDone;
      opStart       <= next_opStart;
      reply         <= next_reply;
    end
  end

  // checks
  sequence freezeReq;
    cmdValid && isFreeze && keyMatch && sanitizeState == SFS_SANITIZE_IDLE_STATE;
  endsequence

  chk_freeze_enters: assert property (@(posedge core_clk) disable iff (!arst_n) // R3
    freezeReq |=> sanitizeState == SFS_SANITIZE_FROZEN_STATE && cmdDone)
    else $error("freeze-lock did not freeze");
  chk_frozen_aborts: assert property (@(posedge core_clk) disable iff (!arst_n) // R4
    cmdValid && isSanitize && !isStatus && sanitizeState == SFS_SANITIZE_FROZEN_STATE
    |=> reply.commandErrorFlags[SFS_ERR_ABORT] && reply.sectorNumber == SFS_RSN_FROZEN)
    else $error("frozen sanitize not aborted");
  chk_frozen_sticks: assert property (@(posedge core_clk) disable iff (!arst_n) // R5
    sanitizeState == SFS_SANITIZE_FROZEN_STATE |=> sanitizeState == SFS_SANITIZE_FROZEN_STATE)
    else $error("left frozen state without reset");
  chk_status_frozen: assert property (@(posedge core_clk) disable iff (!arst_n) // R6
    cmdValid && isStatus && sanitizeState == SFS_SANITIZE_FROZEN_STATE
    |=> cmdDone && !reply.commandErrorFlags[SFS_ERR_ABORT] && reply.sectorCount[SFS_SC_FROZEN])
    else $error("status in frozen state mishandled");
  chk_clear_exit: assert property (@(posedge core_clk) disable iff (!arst_n) // R8
    cmdValid && isStatus && cmd.sectorCount[SFS_SC_CLEAR_FAILED] && failExit &&
    sanitizeState == SFS_SANITIZE_FAILED_STATE |=> sanitizeState == SFS_SANITIZE_IDLE_STATE)
    else $error("clear-failed did not return to idle");
  chk_clear_refused: assert property (@(posedge core_clk) disable iff (!arst_n) // R9
    cmdValid && isStatus && cmd.sectorCount[SFS_SC_CLEAR_FAILED] && !failExit &&
    sanitizeState == SFS_SANITIZE_FAILED_STATE
    |=> reply.deviceStatusFlags[SFS_STS_ERROR] && sanitizeState == SFS_SANITIZE_FAILED_STATE)
    else $error("clear-failed without permission not aborted");
  chk_progress_idle: assert property (@(posedge core_clk) disable iff (!arst_n) // R14
    cmdValid && isStatus && sanitizeState == SFS_SANITIZE_IDLE_STATE && !badFeatSeen
    |=> reply.cylinderLow == 8'hFF && reply.sectorNumber == 8'hFF)
    else $error("idle progress not FFFFh");
  chk_success_flag: assert property (@(posedge core_clk) disable iff (!arst_n) // R10
    sanitizeState == SFS_SANITIZE_OPERATION_STATE && opDone && !opFailed
    |=> succeededFlag && sanitizeState == SFS_SANITIZE_SUCCEEDED_STATE)
    else $error("success flag not set");
  chk_abort_busy: assert property (@(posedge core_clk) disable iff (!arst_n) // R19
    cmdDone && reply.commandErrorFlags[SFS_ERR_ABORT]
    |-> reply.deviceStatusFlags[SFS_STS_ERROR] && !reply.deviceStatusFlags[SFS_STS_BUSY])
    else $error("abort reply flags wrong");

  // request shapes shared by the checks below
  sequence statusReq;
    cmdValid && isStatus;
  endsequence

  sequence overwriteReq;
    cmdValid && isOverwrite && sanitizeState == SFS_SANITIZE_IDLE_STATE;
  endsequence

  sequence startSeen;
    opStart && sanitizeState == SFS_SANITIZE_OPERATION_STATE;
  endsequence

  // every sanitize request is answered on the next edge, anything else never
  chk_done_follows: assert property (@(posedge core_clk) disable iff (!arst_n) // R19
    cmdValid && isSanitize |=> cmdDone)
    else $error("sanitize request not answered");
  chk_done_quiet: assert property (@(posedge core_clk) disable iff (!arst_n) // R19
    !(cmdValid && isSanitize) |=> !cmdDone)
    else $error("reply without sanitize request");
  chk_reply_ready: assert property (@(posedge core_clk) disable iff (!arst_n) // R19
    cmdDone |-> reply.deviceStatusFlags[SFS_STS_READY] && !reply.deviceStatusFlags[SFS_STS_BUSY])
    else $error("reply not ready");

  // outcome and progress fields of the status reply
  chk_in_progress: assert property (@(posedge core_clk) disable iff (!arst_n) // R11
    statusReq ##0 (sanitizeState == SFS_SANITIZE_OPERATION_STATE) |=> reply.sectorCount[SFS_SC_IN_PROGRESS])
    else $error("in-progress flag missing");
  chk_progress_run: assert property (@(posedge core_clk) disable iff (!arst_n) // R13
    statusReq ##0 (sanitizeState == SFS_SANITIZE_OPERATION_STATE && !badFeatSeen)
    |=> {reply.cylinderLow, reply.sectorNumber} == $past(opProgress))
    else $error("running progress not returned");
  chk_progress_done: assert property (@(posedge core_clk) disable iff (!arst_n) // R14
    statusReq ##0 (sanitizeState == SFS_SANITIZE_SUCCEEDED_STATE && !badFeatSeen)
    |=> reply.cylinderLow == 8'hFF && reply.sectorNumber == 8'hFF)
    else $error("progress after success not FFFFh");
  chk_frozen_flag: assert property (@(posedge core_clk) disable iff (!arst_n) // R12
    cmdDone |-> reply.sectorCount[SFS_SC_FROZEN] == (sanitizeState == SFS_SANITIZE_FROZEN_STATE))
    else $error("frozen flag disagrees with state");
  chk_failed_status: assert property (@(posedge core_clk) disable iff (!arst_n) // R16
    statusReq ##0 (!cmd.sectorCount[SFS_SC_CLEAR_FAILED] && sanitizeState == SFS_SANITIZE_FAILED_STATE)
    |=> reply.commandErrorFlags[SFS_ERR_ABORT] && reply.sectorNumber == SFS_RSN_FAILED)
    else $error("status after failed sanitize not aborted");
  chk_unsup_report: assert property (@(posedge core_clk) disable iff (!arst_n) // R7
    statusReq ##0 (badFeatSeen && sanitizeState != SFS_SANITIZE_FAILED_STATE &&
                   sanitizeState != SFS_SANITIZE_FROZEN_STATE)
    |=> reply.commandErrorFlags[SFS_ERR_ABORT] && reply.sectorNumber == SFS_RSN_BADFEAT)
    else $error("unsupported request not reported");

  // wrong freeze keys and unknown features outside the frozen state carry the invalid-feature reason
  chk_bad_key: assert property (@(posedge core_clk) disable iff (!arst_n) // R20
    cmdValid && isFreeze && !keyMatch && !frozenSeen
    |=> reply.commandErrorFlags[SFS_ERR_ABORT] && reply.sectorNumber == SFS_RSN_BADFEAT)
    else $error("wrong freeze key not refused");
  chk_unknown_feat: assert property (@(posedge core_clk) disable iff (!arst_n) // R15
    cmdValid && isSanitize && !isStatus && !isFreeze && !isOverwrite && !frozenSeen
    |=> reply.commandErrorFlags[SFS_ERR_ABORT] && reply.sectorNumber == SFS_RSN_BADFEAT)
    else $error("unsupported feature not refused");

  // an accepted overwrite starts the engine and records its exit permission
  chk_start_records: assert property (@(posedge core_clk) disable iff (!arst_n) // R17
    overwriteReq |=> startSeen ##0 (failExit == $past(cmd.sectorCount[SFS_SC_FAIL_EXIT])))
    else $error("overwrite start or permission wrong");
  chk_success_clears: assert property (@(posedge core_clk) disable iff (!arst_n) // R10
    overwriteReq |=> !succeededFlag)
    else $error("success flag not cleared on start");
  chk_fail_outcome: assert property (@(posedge core_clk) disable iff (!arst_n) // R16
    sanitizeState == SFS_SANITIZE_OPERATION_STATE && opDone && opFailed
    |=> sanitizeState == SFS_SANITIZE_FAILED_STATE)
    else $error("failed run did not reach failed state");
endmodule
`default_nettype wire

// ### verification/sfs_media_model.sv
// media engine model: runs one overwrite per opStart and reports its outcome
`timescale 1ns/10ps
`default_nettype none
module sfs_media_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // run control from the bench
  input  wire logic        failRun,
  input  wire logic [7:0]  runLen,
  input  wire logic [15:0] progBase,
  // handler side
  input  wire logic        opStart,
  output logic             opDone,
  output logic             opFailed,
  output logic [15:0]      opProgress
);
  logic [7:0] left;
  // idle progress shows the inverse so a leak into the reply is seen
  assign opProgress = (left != 8'h00) ? progBase : ~progBase;
  // countdown from start to a one-cycle done pulse
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      left     <= 8'h00;
      opDone   <= 1'h0;
      opFailed <= 1'h0;
    end else begin
      opDone   <= (left == 8'h01);
      opFailed <= (left == 8'h01) && failRun;
      if (opStart) begin
        left <= runLen;
      end else if (left != 8'h00) begin
        left <= left - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// testbench: sanitize freeze-lock and status command sequences
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sfs_pkg::*;
  typedef struct packed {
    logic        abort;
    logic        full;
    logic [7:0]  rsn;
    logic [2:0]  top;
    logic [15:0] prog;
  } sfs_exp_s;
  localparam logic [7:0]  C = SFS_CMD_SANITIZE;
  localparam logic [47:0] KEY = {SFS_KEY_SECNUM_PREV, SFS_KEY_SECNUM_CUR, 8'h00, SFS_KEY_CYLLO_CUR,
                                 8'h00, SFS_KEY_CYLHI_CUR};
  logic        core_clk = 1'h0;
  logic        arst_n = 1'h0;
  logic        retain_rst_n = 1'h0;
  logic        cmdValid = 1'h0;
  sfs_cmd_s    cmd = '0;
  logic        opDone;
  logic        opFailed;
  logic        opStart;
  logic        cmdBusy;
  logic        cmdDone;
  logic [15:0] opProgress;
  sfs_reply_s  reply;
  sfs_state_e  sanitizeState;
  logic        failRun = 1'h1;
  logic [7:0]  runLen = 8'h14;
  logic [15:0] progBase = 16'h0000;
  logic [47:0] pat = 48'h0;
  integer      seed = 89;
  int          fails = 0;
  int          n_tests = 0;
  sfs_exp_s    expQ[$];
  sfs_exp_s    monE;

  sfs_sanitize_handler dut (.core_clk, .arst_n, .retain_rst_n, .cmdValid, .cmd, .opDone, .opFailed,
                            .opProgress, .opStart, .cmdBusy, .cmdDone, .reply, .sanitizeState);
  sfs_media_model model (.core_clk, .arst_n, .failRun, .runLen, .progBase, .opStart, .opDone,
                         .opFailed, .opProgress);

  always #5 core_clk = ~core_clk;

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s saw %h want %h", $time, what, seen, exp);
    end
  endtask

  function automatic sfs_exp_s ab(input logic [7:0] r, input logic chk);
    return {1'h1, chk, r, 3'h0, 16'h0000};
  endfunction

  function automatic sfs_exp_s ok(input logic [2:0] t, input logic [15:0] p, input logic chk);
    return {1'h0, chk, 8'h00, t, p};
  endfunction

  // one command block, held for a single edge; only sanitize commands expect a reply
  task automatic send(input logic [7:0] op, input logic [15:0] feat, input logic [15:0] sc,
                      input logic [47:0] adr, input sfs_exp_s e);
    @(posedge core_clk);
    cmdValid <= 1'h1;
    cmd      <= {op, feat, sc, adr};
    if (op == C) begin
      expQ.push_back(e);
    end
    @(posedge core_clk);
    cmdValid <= 1'h0;
    pat      <= 48'({$random(seed), $random(seed)});
  endtask

  task automatic wait_done();
    for (int i = 0; i < 300 && opDone !== 1'h1; i++) begin
      @(negedge core_clk);
    end
    check(16'(opDone), 16'h0001, "operation end");
    repeat (2) @(posedge core_clk);
  endtask

  task automatic state_is(input sfs_state_e s);
    @(negedge core_clk);
    check(16'(sanitizeState), 16'(s), "state");
  endtask

  task automatic hw_reset();
    @(posedge core_clk);
    arst_n <= 1'h0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'h1;
  endtask

  // reply watcher: each completion takes the oldest note off the queue
  always @(negedge core_clk) begin
    if (cmdDone === 1'h1) begin
      if (expQ.size() == 0) begin
        check(16'h0000, 16'h0001, "reply without command");
      end else begin
        monE = expQ.pop_front();
        check(16'(cmdBusy), 16'h0000, "busy");
        check(16'(reply.commandErrorFlags[SFS_ERR_ABORT]), 16'(monE.abort), "abort");
        check(16'(reply.deviceStatusFlags[SFS_STS_ERROR]), 16'(monE.abort), "error");
        if (monE.abort && monE.full) begin
          check(16'(reply.sectorNumber), 16'(monE.rsn), "reason");
        end
        if (!monE.abort && monE.full) begin
          check(16'(reply.sectorCount[15:13]), 16'(monE.top), "flags");
          check({reply.cylinderLow, reply.sectorNumber}, monE.prog, "progress");
        end
      end
    end
  end

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    fails++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    arst_n       <= 1'h1;
    retain_rst_n <= 1'h1;
    progBase     <= 16'($random(seed));
    send(C, SFS_FEAT_STATUS, 16'h0000, pat, ok(3'h0, 16'hFFFF, 1'h1));
    // overwrite that may leave failure through status
    send(C, SFS_FEAT_OVERWRITE, 16'h0010, pat, ok(3'h0, 16'h0000, 1'h0));
    send(C, SFS_FEAT_STATUS, 16'h0000, pat, ok(3'h2, progBase, 1'h1));
    send(C, SFS_FEAT_FREEZE, pat[15:0], KEY, ab(SFS_RSN_NONE, 1'h1));
    wait_done();
    send(C, SFS_FEAT_STATUS, 16'h0000, pat, ab(SFS_RSN_FAILED, 1'h1));
    send(C, SFS_FEAT_STATUS, 16'h0001, pat, ok(3'h0, 16'hFFFF, 1'h1));
    state_is(SFS_SANITIZE_IDLE_STATE);
    // failure without exit permission refuses the clear request
    @(posedge core_clk);
    runLen <= 8'h03 + 8'(pat[2:0]);
    send(C, SFS_FEAT_OVERWRITE, pat[15:0] & 16'hFFEF, pat, ok(3'h0, 16'h0000, 1'h0));
    wait_done();
    send(C, SFS_FEAT_STATUS, 16'h0001, pat, ab(SFS_RSN_FAILED, 1'h1));
    state_is(SFS_SANITIZE_FAILED_STATE);
    hw_reset();
    failRun <= 1'h0;
    send(C, SFS_FEAT_OVERWRITE, pat[15:0], pat, ok(3'h0, 16'h0000, 1'h0));
    wait_done();
    send(C, SFS_FEAT_STATUS, 16'h0000, pat, ok(3'h4, 16'hFFFF, 1'h1));
    hw_reset();
    send(C, SFS_FEAT_STATUS, 16'h0000, pat, ok(3'h4, 16'hFFFF, 1'h1));
    // refused requests: unknown feature and a wrong freeze key
    send(C, 16'h0100 | 16'(pat[7:0]), pat[15:0], pat, ab(SFS_RSN_BADFEAT, 1'h1));
    send(C, SFS_FEAT_FREEZE, pat[15:0], ~KEY, ab(SFS_RSN_BADFEAT, 1'h1));
    send(C, SFS_FEAT_STATUS, 16'h0000, pat, ab(SFS_RSN_BADFEAT, 1'h1));
    send(C, SFS_FEAT_FREEZE, pat[15:0], KEY, ok(3'h5, 16'hFFFF, 1'h1));
    state_is(SFS_SANITIZE_FROZEN_STATE);
    send(C, SFS_FEAT_OVERWRITE, 16'h0010, pat, ab(SFS_RSN_FROZEN, 1'h1));
    send(C, SFS_FEAT_FREEZE, pat[15:0], KEY, ab(SFS_RSN_FROZEN, 1'h1));
    send(8'hEC, SFS_FEAT_STATUS, 16'h0000, pat, ok(3'h0, 16'h0000, 1'h0));
    send(C, SFS_FEAT_STATUS, 16'h0000, pat, ok(3'h5, 16'hFFFF, 1'h1));
    hw_reset();
    send(C, SFS_FEAT_STATUS, 16'h0000, pat, ok(3'h4, 16'hFFFF, 1'h1));
    state_is(SFS_SANITIZE_IDLE_STATE);
    repeat (3) @(posedge core_clk);
    check(16'(expQ.size()), 16'h0000, "replies missing");
    test_done();
  end
endmodule
`default_nettype wire
